// file: tpu_pkg.sv
// Constants, opcodes and register map of the token processing unit datapath.
// Overview of operation
// - Two's complement A becomes sign-magnitude, sign to X.
// - Sign-magnitude to two's complement; overflow sets X control.
// - Differing signs, both words nonzero: high minus one, low complemented.
// - Running sum adds each token's data field.
// - Type 1 tokens dropped; type 2 carry sum.
// - Type 2 identifier bumped after earlier overflow.
// - Cyclic read, route flag one, size match: type 2.
// - Tally, route flag zero, size match: type 2.
// - Duplicate: A to X, Y takes A control.
// - Logical ops on X with A sign; Y sign and data zero.
// - Sign-magnitude add, larger magnitude gives sign.
// - Count variants put normalisation count on Y.
// - Product high on X, low on Y, signs ORed.
// - Test-to-flag, plain test and test-and-swap behaviours.
// - Running sum only paired; sum appears on X.
// - Overflow-indicator Y reads one on magnitude overflow.
// - Count equals leading zeros of X data.
package tpu_pkg;
  localparam int DW  = 16;
  localparam int IDW = 8;
  localparam int AW  = 4;

  // Opcodes.
  localparam logic [4:0] OP_OR     = 5'h00;
  localparam logic [4:0] OP_AND    = 5'h01;
  localparam logic [4:0] OP_XOR    = 5'h02;
  localparam logic [4:0] OP_INVAND = 5'h03;
  localparam logic [4:0] OP_NOT    = 5'h0c;
  localparam logic [4:0] OP_FLAG   = 5'h08;
  localparam logic [4:0] OP_TEST   = 5'h09;
  localparam logic [4:0] OP_SWAP   = 5'h11;
  localparam logic [4:0] OP_SUM    = 5'h12;
  localparam logic [4:0] OP_DUP    = 5'h13;
  localparam logic [4:0] OP_FIXUP  = 5'h14;
  localparam logic [4:0] OP_T2SM   = 5'h0e;
  localparam logic [4:0] OP_SM2T   = 5'h0f;
  localparam logic [4:0] OP_ADD    = 5'h18;
  localparam logic [4:0] OP_SUB    = 5'h19;
  localparam logic [4:0] OP_MUL    = 5'h1a;
  localparam logic [4:0] OP_ADDC   = 5'h1c;
  localparam logic [4:0] OP_SUBC   = 5'h1d;
  localparam logic [4:0] OP_MULC   = 5'h1e;

  // Condition select codes for the compare group.
  localparam logic [2:0] CND_EQ = 3'h1;
  localparam logic [2:0] CND_LT = 3'h2;
  localparam logic [2:0] CND_LE = 3'h3;
  localparam logic [2:0] CND_GT = 3'h4;
  localparam logic [2:0] CND_GE = 3'h5;
  localparam logic [2:0] CND_NE = 3'h6;

  // Pairing of the running sum with its partner operation.
  typedef enum logic [1:0] {
    PAIR_NONE  = 2'h0,
    PAIR_CYCS  = 2'h1,
    PAIR_CYCL  = 2'h2,
    PAIR_TALLY = 2'h3
  } tpu_pair_t;

  // Register byte addresses and fields.
  localparam logic [AW-1:0] REG_STATUS = 4'h0;
  localparam logic [AW-1:0] REG_MASK   = 4'h4;
  localparam logic [AW-1:0] REG_CTRL   = 4'h8;
  localparam logic [AW-1:0] REG_ACCUM  = 4'hc;
  localparam int ST_ACC_OVF  = 0;
  localparam int ST_CONV_OVF = 1;
  localparam int ST_ADD_OVF  = 2;
  localparam int ST_BAD_OP   = 3;
  localparam int NEVT        = 4;
  localparam int CTRL_ACC_CLR = 0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [DW-1:0] D_ZERO = 16'h0000;
  localparam logic [DW-1:0] D_ONE  = 16'h0001;
  localparam logic [DW-1:0] D_POSMAX = 16'h7fff;
  localparam logic [DW-1:0] D_NEGMAX = 16'h8000;
endpackage : tpu_pkg

// file: tpu_alu.sv
// Token processing unit datapath with running sum and AXI4-Lite status registers.
`timescale 1ns/1ps
module tpu_alu import tpu_pkg::*; (
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst,
  // Incoming token pair.
  input  wire logic              inValid,
  input  wire logic [4:0]        opcode,
  input  wire logic [2:0]        conditionSelectField,
  input  wire logic [IDW-1:0]    tokenId,
  input  wire logic              aCtrl,
  input  wire logic              aSign,
  input  wire logic [DW-1:0]     aData,
  input  wire logic              bCtrl,
  input  wire logic              bSign,
  input  wire logic [DW-1:0]     bData,
  // Running-sum pairing context.
  input  wire tpu_pair_t         pairMode,
  input  wire logic              tokenRouteFlag,
  input  wire logic              sizeMatch,
  // Result pair to the next stage.
  output logic                   outValid,
  output logic [IDW-1:0]         outId,
  output logic                   xCtrl,
  output logic                   xSign,
  output logic [DW-1:0]          xData,
  output logic                   yCtrl,
  output logic                   ySign,
  output logic [DW-1:0]          yData,
  // AXI4-Lite slave.
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [AW-1:0]     awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [AW-1:0]     araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // Interrupt.
  output logic                   irq
);

  // Sign-magnitude add: returns {overflow, sign, magnitude}.
  function automatic logic [DW+1:0] smAdd(input logic sa, input logic [DW-1:0] ma,
                                          input logic sb, input logic [DW-1:0] mb);
    logic [DW:0] s;
    s = {1'b0, ma} + {1'b0, mb};
    if (sa == sb) begin
      return {s[DW], sa, s[DW-1:0]};
    end else if (ma >= mb) begin
      return {1'b0, sa, ma - mb};
    end else begin
      return {1'b0, sb, mb - ma};
    end
  endfunction : smAdd

  // Leading zero count of a data word, zero-extended to the data width.
  function automatic logic [DW-1:0] normCount(input logic [DW-1:0] d);
    logic [4:0] n;
    logic       hit;
    n = 5'h00;
    hit = 1'b0;
    for (int i = DW - 1; i >= 0; i--) begin
      if (!hit && !d[i]) begin
        n = n + 5'h01;
      end else begin
        hit = 1'b1;
      end
    end
    return {11'h000, n};
  endfunction : normCount

  // Signed compare of two sign-magnitude operands under a condition code.
  function automatic logic smTest(input logic [2:0] c, input logic sa, input logic [DW-1:0] ma,
                                  input logic sb, input logic [DW-1:0] mb);
    logic signed [DW+1:0] va;
    logic signed [DW+1:0] vb;
    va = sa ? -$signed({2'h0, ma}) : $signed({2'h0, ma});
    vb = sb ? -$signed({2'h0, mb}) : $signed({2'h0, mb});
    case (c)
      CND_EQ:  return va == vb;
      CND_LT:  return va < vb;
      CND_LE:  return va <= vb;
      CND_GT:  return va > vb;
      CND_GE:  return va >= vb;
      CND_NE:  return va != vb;
      default: return 1'b0;
    endcase
  endfunction : smTest

  // Register state.
  logic [NEVT-1:0] status_r;
  logic [NEVT-1:0] mask_r;
  logic [DW-1:0]   accSum_r;
  logic            accOvf_r;
  logic [AW-1:0]   awAddr_r;
  logic [31:0]     wData_r;
  logic [3:0]      wStrb_r;
  logic            awHeld_r;
  logic            wHeld_r;

  // Combinational results.
  logic            cx, sx, cy, sy, keep, isType2;
  logic [DW-1:0]   dx, dy;
  logic [IDW-1:0]  idOut;
  logic [DW+1:0]   addRes;
  logic [2*DW-1:0] prod;
  logic [DW:0]     accNext;
  logic            cond, sumOp;
  logic [NEVT-1:0] evt;

  assign sumOp   = inValid && (opcode == OP_SUM);
  assign accNext = {1'b0, accSum_r} + {1'b0, aData};
  // Type 2 classification needs an exact pairing context.
  assign isType2 = (((pairMode == PAIR_CYCS) || (pairMode == PAIR_CYCL)) &&
                    tokenRouteFlag && sizeMatch) ||
                   ((pairMode == PAIR_TALLY) && !tokenRouteFlag && sizeMatch);

  // Result selection; every path defaults to passing both sides through.
  always_comb begin
    cx = aCtrl;
    sx = aSign;
    dx = aData;
    cy = bCtrl;
    sy = bSign;
    dy = bData;
    keep = 1'b1;
    idOut = tokenId;
    evt = '0;
    cond = smTest(conditionSelectField, aSign, aData, bSign, bData);
    // Subtract is an add with the B sign flipped; A-minus-B sign falls out.
    addRes = smAdd(aSign, aData, (opcode == OP_SUB || opcode == OP_SUBC) ? ~bSign : bSign,
                   bData);
    prod = aData * bData;
    case (opcode)
      OP_OR, OP_AND, OP_XOR, OP_INVAND, OP_NOT: begin
        case (opcode)
          OP_OR:     dx = aData | bData;
          OP_AND:    dx = aData & bData;
          OP_XOR:    dx = aData ^ bData;
          OP_INVAND: dx = ~aData & bData;
          default:   dx = ~aData;
        endcase
        sy = 1'b0;
        dy = D_ZERO;
      end
      OP_ADD, OP_SUB, OP_ADDC, OP_SUBC: begin
        sx = addRes[DW];
        dx = addRes[DW-1:0];
        sy = addRes[DW];
        evt[ST_ADD_OVF] = addRes[DW+1];
        if (opcode == OP_ADDC || opcode == OP_SUBC) begin
          dy = normCount(addRes[DW-1:0]);
        end else begin
          dy = addRes[DW+1] ? D_ONE : D_ZERO;
        end
      end
      OP_MUL, OP_MULC: begin
        sx = aSign | bSign;
        sy = aSign | bSign;
        dx = prod[2*DW-1:DW];
        dy = (opcode == OP_MULC) ? normCount(prod[2*DW-1:DW]) : prod[DW-1:0];
      end
      OP_FLAG: begin
        cx = cond;
        cy = cond;
        sx = 1'b0;
        sy = 1'b0;
        dx = cond ? D_ONE : D_ZERO;
        dy = D_ZERO;
      end
      OP_TEST: begin
        cx = cond;
        cy = cond;
      end
      OP_SWAP: begin
        if (!cond) begin
          cx = bCtrl;
          sx = bSign;
          dx = bData;
          cy = aCtrl;
          sy = aSign;
          dy = aData;
        end
      end
      OP_T2SM: begin
        sx = aData[DW-1];
        dx = aData[DW-1] ? D_ZERO - aData : aData;
        sy = 1'b0;
        dy = D_ZERO;
      end
      OP_SM2T: begin
        dx = aSign ? D_ZERO - aData : aData;
        evt[ST_CONV_OVF] = aSign ? (aData > D_NEGMAX) : (aData > D_POSMAX);
        cx = aCtrl | evt[ST_CONV_OVF];
        sy = 1'b0;
        dy = D_ZERO;
      end
      OP_FIXUP: begin
        // Differing signs with both words nonzero borrow one from the high word.
        if (aSign != bSign) begin
          if (aData != D_ZERO && bData != D_ZERO) begin
            dx = aData - D_ONE;
            sy = aSign;
            dy = D_ZERO - bData;
          end else if (aData == D_ZERO && bData != D_ZERO) begin
            sx = bSign;
            sy = bSign;
          end else begin
            sy = aSign;
          end
        end
      end
      OP_DUP: begin
        cy = aCtrl;
      end
      OP_SUM: begin
        // Only a type 2 token leaves; it carries the sum on X.
        keep = isType2;
        sx = 1'b0;
        dx = accNext[DW-1:0];
        cy = 1'b0;
        sy = 1'b0;
        dy = D_ZERO;
        idOut = accOvf_r ? tokenId + 8'h01 : tokenId;
        evt[ST_ACC_OVF] = accNext[DW];
        evt[ST_BAD_OP] = (pairMode == PAIR_NONE);
      end
      default: begin
        evt[ST_BAD_OP] = 1'b1;
      end
    endcase
  end

  // Result registers; discarded tokens simply produce no valid.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outValid <= 1'b0;
      outId <= '0;
      xCtrl <= 1'b0;
      xSign <= 1'b0;
      xData <= D_ZERO;
      yCtrl <= 1'b0;
      ySign <= 1'b0;
      yData <= D_ZERO;
    end else begin
      outValid <= inValid && keep;
      if (inValid) begin
        outId <= idOut;
        xCtrl <= cx;
        xSign <= sx;
        xData <= dx;
        yCtrl <= cy;
        ySign <= sy;
        yData <= dy;
      end
    end
  end

  // Accumulator; a type 2 readout restarts the sum for the next block.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      accSum_r <= D_ZERO;
      accOvf_r <= 1'b0;
    end else if (sumOp) begin
      if (isType2) begin
        accSum_r <= D_ZERO;
        accOvf_r <= 1'b0;
      end else begin
        accSum_r <= accNext[DW-1:0];
        accOvf_r <= accOvf_r | accNext[DW];
      end
    end else if (awHeld_r && wHeld_r && !bvalid && awAddr_r == REG_CTRL &&
                 wStrb_r[0] && wData_r[CTRL_ACC_CLR]) begin
      accSum_r <= D_ZERO;
      accOvf_r <= 1'b0;
    end
  end

  // Write channel: address and data are held until both arrive.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      mask_r <= '0;
    end else begin
      if (awvalid && awready) begin
        awAddr_r <= awaddr;
        awHeld_r <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wData_r <= wdata;
        wStrb_r <= wstrb;
        wHeld_r <= 1'b1;
        wready <= 1'b0;
      end
      if (awHeld_r && wHeld_r && !bvalid) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awAddr_r == REG_MASK || awAddr_r == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
        if (awAddr_r == REG_MASK && wStrb_r[0]) begin
          mask_r <= wData_r[NEVT-1:0];
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read channel; a status read clears what it returned.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= RESP_OKAY;
        case (araddr)
          REG_STATUS: rdata <= {28'h0000000, status_r};
          REG_MASK:   rdata <= {28'h0000000, mask_r};
          REG_CTRL:   rdata <= 32'h00000000;
          REG_ACCUM:  rdata <= {15'h0000, accOvf_r, accSum_r};
          default: begin
            rdata <= 32'h00000000;
            rresp <= RESP_SLVERR;
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Sticky events: a new event in the clearing cycle survives the clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~((arvalid && arready && araddr == REG_STATUS) ? status_r : '0))
                  | (inValid ? evt : '0);
    end
  end

  // Interrupt level, registered so the pin never glitches.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
    end
  end

  // Checks on the result path.
  logic pastSm2tOvf;
  assign pastSm2tOvf = inValid && opcode == OP_SM2T &&
                       (aSign ? (aData > D_NEGMAX) : (aData > D_POSMAX));

  logic_yzero_a: assert property (@(posedge clock) disable iff (rst)
    inValid && (opcode == OP_OR || opcode == OP_XOR) |=> yData == D_ZERO && !ySign)
    else $error("Logical op left Y nonzero.");
  conv_sign_a: assert property (@(posedge clock) disable iff (rst)
    inValid && opcode == OP_T2SM |=> xSign == $past(aData[DW-1]) && !xData[DW-1] ||
    xData == D_NEGMAX)
    else $error("Conversion sign wrong.");
  conv_ovf_a: assert property (@(posedge clock) disable iff (rst)
    pastSm2tOvf |=> xCtrl && outValid)
    else $error("Conversion overflow not flagged.");
  dup_ctrl_a: assert property (@(posedge clock) disable iff (rst)
    inValid && opcode == OP_DUP |=> yCtrl == $past(aCtrl) && yData == $past(bData)
    && xData == $past(aData))
    else $error("Control duplicate wrong.");
  sum_drop_a: assert property (@(posedge clock) disable iff (rst)
    sumOp && !isType2 |=> !outValid)
    else $error("Type 1 token passed.");
  id_bump_a: assert property (@(posedge clock) disable iff (rst)
    sumOp && isType2 && accOvf_r |=> outValid && outId == $past(tokenId) + 8'h01)
    else $error("Identifier not bumped.");
  mul_sign_a: assert property (@(posedge clock) disable iff (rst)
    inValid && opcode == OP_MUL |=> xSign == ($past(aSign) | $past(bSign)))
    else $error("Product sign wrong.");
  flag_false_a: assert property (@(posedge clock) disable iff (rst)
    inValid && opcode == OP_FLAG && !cond |=> !xCtrl && !yCtrl && xData == D_ZERO)
    else $error("False test not zeroed.");
  add_ovf_a: assert property (@(posedge clock) disable iff (rst)
    inValid && opcode == OP_ADD && addRes[DW+1] |=> yData == D_ONE)
    else $error("Overflow indicator missing.");
  norm_count_a: assert property (@(posedge clock) disable iff (rst)
    inValid && opcode == OP_ADDC |=> yData == normCount(xData))
    else $error("Shift count wrong.");

  sum_read_c: cover property (@(posedge clock) disable iff (rst) sumOp && isType2 ##1 outValid);
  swap_c: cover property (@(posedge clock) disable iff (rst) inValid && opcode == OP_SWAP && !cond);
  irq_c: cover property (@(posedge clock) disable iff (rst) !irq ##1 irq);

endmodule : tpu_alu

// file: tpu_sink_model.sv
// Sink model of the next pipeline stage, recording each result it is handed.
`timescale 1ns/1ps
module tpu_sink_model import tpu_pkg::*; (
  // Clock and reset.
  input  wire logic           clock,
  input  wire logic           rst,
  // Result pair from the datapath.
  input  wire logic           outValid,
  input  wire logic [IDW-1:0] outId,
  input  wire logic [35:0]    res
);
  int             count;
  logic [IDW-1:0] lastId;
  logic [35:0]    lastRes;

  // The next stage never stalls, so a result is taken in the one cycle it is shown.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count   <= 0;
      lastId  <= '0;
      lastRes <= '0;
    end else if (outValid) begin
      count   <= count + 1;
      lastId  <= outId;
      lastRes <= res;
    end
  end
endmodule : tpu_sink_model

// file: token_processing_unit_alu_tb_top.sv
// Self-checking testbench of the token datapath, its register bus and interrupt.
`timescale 1ns/1ps
module token_processing_unit_alu_tb_top import tpu_pkg::*; ;
  logic           clock, rst, inValid, aCtrl, aSign, bCtrl, bSign;
  logic           tokenRouteFlag, sizeMatch, outValid, xCtrl, xSign, yCtrl, ySign, irq;
  logic [4:0]     opcode;
  logic [2:0]     conditionSelectField;
  logic [IDW-1:0] tokenId, outId;
  logic [DW-1:0]  aData, bData, xData, yData;
  tpu_pair_t      pairMode;
  logic           awvalid, awready, wvalid, wready, bvalid, bready;
  logic           arvalid, arready, rvalid, rready;
  logic [AW-1:0]  awaddr, araddr;
  logic [31:0]    wdata, rdata, rd;
  logic [3:0]     wstrb;
  logic [1:0]     bresp, rresp, rs;
  int             errCount = 0;
  int             samplesChecked = 0;

  // Datapath under test.
  tpu_alu DUT (.clock, .rst, .inValid, .opcode, .conditionSelectField, .tokenId,
    .aCtrl, .aSign, .aData, .bCtrl, .bSign, .bData, .pairMode, .tokenRouteFlag,
    .sizeMatch, .outValid, .outId, .xCtrl, .xSign, .xData, .yCtrl, .ySign, .yData,
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .irq);

  // Next pipeline stage.
  tpu_sink_model sinkModel (.clock, .rst, .outValid, .outId,
    .res({xCtrl, xSign, xData, yCtrl, ySign, yData}));

  // Free-running 40 MHz clock.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (errCount == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Compares one value and counts it.
  task automatic check(input logic [35:0] got, input logic [35:0] exp, input string msg);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  // A wait that runs out is counted and ends the run.
  task automatic bound(input int n);
    if (n > 50) begin
      errCount++;
      conclude();
    end
  endtask : bound

  // One register write; address and data are offered together and each released when taken.
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic aw, w, b;
    n = 0;
    b = 1'b0;
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    while (!b) begin
      // Ready lines are registered, so the value at mid-cycle is the one the edge sees.
      @(negedge clock);
      aw = awvalid && awready;
      w  = wvalid && wready;
      b  = bvalid;
      r  = bresp;
      @(posedge clock);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      n++;
      bound(n);
    end
  endtask : axiWrite

  // One register read.
  task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ar, got;
    n   = 0;
    got = 1'b0;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    while (!got) begin
      @(negedge clock);
      ar  = arvalid && arready;
      got = rvalid;
      d   = rdata;
      r   = rresp;
      @(posedge clock);
      if (ar) arvalid <= 1'b0;
      if (got) rready <= 1'b0;
      n++;
      bound(n);
    end
  endtask : axiRead

  // Hands one token pair in and waits a fixed one edge after it is taken, by which the sink has recorded any result.
  task automatic send(input logic [4:0] o, input logic [2:0] c, input logic [7:0] id,
                      input logic [17:0] a, input logic [17:0] b);
    @(posedge clock);
    inValid                 <= 1'b1;
    opcode                  <= o;
    conditionSelectField    <= c;
    tokenId                 <= id;
    {aCtrl, aSign, aData}   <= a;
    {bCtrl, bSign, bData}   <= b;
    @(posedge clock);
    inValid <= 1'b0;
    @(posedge clock);
    #1;
  endtask : send

  // Token whose result must appear exactly once with the given value.
  task automatic tok(input logic [4:0] o, input logic [2:0] c, input logic [17:0] a,
                     input logic [17:0] b, input logic [35:0] exp,
                     input logic [35:0] msk = 36'hfffffffff);
    int n;
    n = sinkModel.count;
    send(o, c, 8'h00, a, b);
    check(36'(sinkModel.count - n), 36'h1, "result count");
    check(sinkModel.lastRes & msk, exp & msk, "result");
  endtask : tok

  // Running-sum token; whether it comes out follows from its pairing context.
  task automatic sumTok(input tpu_pair_t p, input logic r, input logic s,
                        input logic [15:0] d, input logic [7:0] id, input logic [7:0] expId);
    logic t2;
    int   n;
    t2 = ((p == PAIR_CYCS || p == PAIR_CYCL) && r && s) || (p == PAIR_TALLY && !r && s);
    n  = sinkModel.count;
    @(posedge clock);
    pairMode       <= p; // Sum is only ever issued paired.
    tokenRouteFlag <= r;
    sizeMatch      <= s;
    send(OP_SUM, 3'h0, id, {2'b00, d}, 18'h0);
    check(36'(sinkModel.count - n), 36'(t2), "sum pass"); // Type filter.
    if (t2) check(36'(sinkModel.lastId), 36'(expId), "sum id"); // Identifier.
  endtask : sumTok

  // Logical group on a signed operand with both control bits differing.
  task automatic scenLogic();
    tok(OP_OR, 3'h0, {2'b11, 16'h1234}, {2'b00, 16'h00ff}, {2'b11, 16'h12ff, 18'h0}); // Or.
    tok(OP_AND, 3'h0, {2'b11, 16'h1234}, {2'b00, 16'h00ff}, {2'b11, 16'h0034, 18'h0}); // And.
    tok(OP_XOR, 3'h0, {2'b11, 16'h1234}, {2'b00, 16'h00ff}, {2'b11, 16'h12cb, 18'h0}); // Xor.
    tok(OP_INVAND, 3'h0, {2'b11, 16'h1234}, {2'b00, 16'h00ff}, {2'b11, 16'h00cb, 18'h0});
    tok(OP_NOT, 3'h0, {2'b11, 16'h1234}, {2'b00, 16'h00ff}, {2'b11, 16'hedcb, 18'h0}); // Not.
  endtask : scenLogic

  // Sign-magnitude arithmetic, overflow marker, counts and product.
  task automatic scenArith();
    tok(OP_ADD, 3'h0, {2'b00, 16'h0005}, {2'b01, 16'h0008}, {2'b01, 16'h0003, 2'b01, 16'h0});
    tok(OP_ADD, 3'h0, {2'b00, 16'hffff}, {2'b10, 16'h0002}, {2'b00, 16'h0001, 2'b10, 16'h1});
    tok(OP_SUB, 3'h0, {2'b01, 16'h0003}, {2'b01, 16'h0008}, {2'b00, 16'h0005, 2'b00, 16'h0});
    tok(OP_SUB, 3'h0, {2'b00, 16'h0010}, {2'b01, 16'h0020}, {2'b00, 16'h0030, 2'b00, 16'h0});
    tok(OP_ADDC, 3'h0, {2'b00, 16'h00f0}, {2'b00, 16'h0010}, {2'b00, 16'h0100, 2'b00, 16'h7});
    tok(OP_SUBC, 3'h0, {2'b00, 16'h8000}, {2'b00, 16'h0000}, {2'b00, 16'h8000, 18'h0});
    tok(OP_SUBC, 3'h0, {2'b00, 16'h0005}, {2'b00, 16'h0005}, {18'h0, 2'b00, 16'h10});
    tok(OP_MUL, 3'h0, {2'b01, 16'h1234}, {2'b00, 16'h0100}, {2'b01, 16'h0012, 2'b01, 16'h3400});
    tok(OP_MULC, 3'h0, {2'b01, 16'h1234}, {2'b00, 16'h0100}, {2'b01, 16'h0012, 2'b01, 16'hb});
  endtask : scenArith

  // Every condition code on minus nine against three, plus flag and swap outcomes.
  task automatic scenCompare();
    logic t;
    for (int c = 1; c <= 6; c++) begin
      t = (c == CND_LT || c == CND_LE || c == CND_NE);
      tok(OP_TEST, 3'(c), {2'b01, 16'h0009}, {2'b00, 16'h0003},
          {t, 1'b1, 16'h0009, t, 1'b0, 16'h0003}); // Plain test.
    end
    tok(OP_FLAG, CND_EQ, {2'b10, 16'h7}, {2'b10, 16'h7}, {2'b10, 16'h1, 2'b10, 16'h0});
    tok(OP_FLAG, CND_LT, {2'b10, 16'h7}, {2'b10, 16'h7}, 36'h0); // False flag.
    tok(OP_SWAP, CND_LE, {2'b00, 16'h3}, {2'b10, 16'h9}, {2'b00, 16'h3, 2'b10, 16'h9});
    tok(OP_SWAP, CND_GE, {2'b00, 16'h3}, {2'b10, 16'h9}, {2'b10, 16'h9, 2'b00, 16'h3});
  endtask : scenCompare

  // Duplicate, both conversions, the sign-magnitude to two's complement overflow boundaries, long fixup.
  task automatic scenMisc();
    tok(OP_DUP, 3'h0, {2'b11, 16'h1111}, {2'b00, 16'h2222}, {2'b11, 16'h1111, 2'b10, 16'h2222});
    tok(OP_T2SM, 3'h0, {2'b00, 16'hfffe}, 18'h0, {2'b01, 16'h0002, 18'h0}, 36'h7ffffffff);
    tok(OP_SM2T, 3'h0, {2'b01, 16'h0002}, 18'h0, {2'b00, 16'hfffe, 18'h0}, 36'hbffffffff);
    tok(OP_SM2T, 3'h0, {2'b00, 16'h8000}, 18'h0, 36'h800000000, 36'h800000000); // Overflow.
    tok(OP_SM2T, 3'h0, {2'b01, 16'h8001}, 18'h0, 36'h800000000, 36'h800000000); // Under.
    tok(OP_SM2T, 3'h0, {2'b01, 16'h8000}, 18'h0, 36'h0, 36'h800000000); // Just fits.
    tok(OP_FIXUP, 3'h0, {2'b00, 16'h1234}, {2'b01, 16'h5678}, {2'b00, 16'h1233, 2'b00, 16'ha988});
    tok(OP_FIXUP, 3'h0, {2'b01, 16'h1234}, {2'b00, 16'h5678}, {2'b01, 16'h1233, 2'b01, 16'ha988});
    tok(OP_FIXUP, 3'h0, {2'b00, 16'h1234}, {2'b00, 16'h5678}, {2'b00, 16'h1234, 2'b00, 16'h5678});
  endtask : scenMisc

  // Running sum across all pairings, discards, readout and overflow identifier.
  task automatic scenSum();
    axiWrite(REG_CTRL, 32'h1, rs);
    check(36'(rs), 36'(RESP_OKAY), "ctrl write");
    sumTok(PAIR_TALLY, 1'b0, 1'b0, 16'h0010, 8'h20, 8'h20); // Kept in the sum.
    sumTok(PAIR_TALLY, 1'b0, 1'b0, 16'h0020, 8'h20, 8'h20);
    sumTok(PAIR_CYCS, 1'b0, 1'b1, 16'h0000, 8'h20, 8'h20);
    sumTok(PAIR_TALLY, 1'b1, 1'b1, 16'h0000, 8'h20, 8'h20);
    sumTok(PAIR_TALLY, 1'b0, 1'b1, 16'h0003, 8'h21, 8'h21);
    check(sinkModel.lastRes & 36'h7fffdffff, {2'b00, 16'h0033, 18'h0}, "sum");
    sumTok(PAIR_CYCL, 1'b1, 1'b1, 16'h0004, 8'h30, 8'h30);
    check(sinkModel.lastRes & 36'h7fffdffff, {2'b00, 16'h0004, 18'h0}, "sum");
    sumTok(PAIR_CYCS, 1'b1, 1'b0, 16'hfff0, 8'h40, 8'h40);
    sumTok(PAIR_CYCS, 1'b1, 1'b0, 16'h0020, 8'h40, 8'h40);
    sumTok(PAIR_CYCS, 1'b1, 1'b1, 16'h0001, 8'h40, 8'h41); // After overflow.
    sumTok(PAIR_TALLY, 1'b0, 1'b1, 16'h0002, 8'h50, 8'h50); // Overflow was cleared.
    pairMode <= PAIR_NONE;
  endtask : scenSum

  // Registers, masking, read-clear and the interrupt line.
  task automatic scenRegs();
    axiRead(REG_MASK, rd, rs);
    check(36'(rd), 36'h0, "mask reset");
    axiRead(REG_STATUS, rd, rs);
    axiWrite(REG_MASK, 32'h4, rs);
    tok(OP_ADD, 3'h0, {2'b00, 16'hffff}, {2'b00, 16'h2}, {2'b00, 16'h1, 2'b00, 16'h1});
    repeat (2) @(posedge clock);
    #1;
    check(36'(irq), 36'h1, "irq set");
    axiRead(REG_STATUS, rd, rs);
    check(36'(rd), 36'h4, "status");
    repeat (3) @(posedge clock);
    #1;
    check(36'(irq), 36'h0, "irq clear");
    tok(5'h05, 3'h0, {2'b10, 16'h00aa}, {2'b01, 16'h00bb}, {2'b10, 16'h00aa, 2'b01, 16'h00bb});
    repeat (2) @(posedge clock);
    #1;
    check(36'(irq), 36'h0, "irq masked");
    axiRead(REG_STATUS, rd, rs);
    check(36'(rd), 36'h8, "bad opcode");
    axiWrite(REG_STATUS, 32'hf, rs);
    check(36'(rs), 36'(RESP_SLVERR), "status write");
    axiRead(REG_ACCUM, rd, rs);
    check(36'(rs), 36'(RESP_OKAY), "accum read");
  endtask : scenRegs

  // Main sequence.
  initial begin
    {inValid, opcode, conditionSelectField, tokenId} = '0;
    {aCtrl, aSign, aData, bCtrl, bSign, bData} = '0;
    {tokenRouteFlag, sizeMatch, awvalid, awaddr, wvalid, wdata, wstrb} = '0;
    {bready, arvalid, araddr, rready} = '0;
    pairMode = PAIR_NONE;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    scenLogic();
    scenArith();
    scenCompare();
    scenMisc();
    scenSum();
    scenRegs();
    conclude();
  end
endmodule : token_processing_unit_alu_tb_top
